// ==== rtl/aflg_top.sv ====
// Functional notes
// - Flags as destination of a flag-changing op keeps ALU flags, not data.
// - Clearing the flags register sets zero and keeps the other flags.
// - Flags register is 8 bits; top three read zero, low five R/W.
// - Negative flag, bit 4, copies result MSB.
// - Overflow flag, bit 3, marks signed overflow changing the sign bit.
// - Zero flag, bit 2, set when the result is zero.
// - Nibble carry, bit 1, is the carry out of bit 3 on add/sub.
// - Carry, bit 0, is the carry out of the MSB on add/sub.
// - Subtract adds the two's complement; carries act as inverted borrows.
// - Rotates load nibble carry from source bit 4 or bit 3.
// - Rotates load carry from source high or low bit.
// - Flags register works as source or destination of any op.
`timescale 1ns/1ps
`include "aflg_cfg.svh"
module aflg_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] opa;
      logic [7:0] opb;
      aflg_pkg::aflg_op_e op;
      logic [2:0] bsel;
      logic src_f;
      logic dst_f;
      logic [7:0] res;
      logic go;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } aflg_top_s;

   aflg_top_s s_r;
   aflg_top_s s_nxt;
   aflg_if f ();
   logic acc;
   logic wr_done;
   logic flags_wr;

   // ----------------------------------------------------------------
   // Datapath and flag register
   // ----------------------------------------------------------------
   aflg_alu u_alu (
      .f (f.alu)
   );

   aflg_freg u_freg (
      .pclk (pclk),
      .presetn (presetn),
      .f (f.freg)
   );

   // Address decode for the error answer; the read mux has its own case
   function automatic logic addr_ok(logic [7:0] a);
      return (a == `AFLG_OFF_OPA) || (a == `AFLG_OFF_OPB) ||
             (a == `AFLG_OFF_CMD) || (a == `AFLG_OFF_RES) ||
             (a == `AFLG_OFF_FLAGS);
   endfunction : addr_ok

   // Read data; upper bits of the flags word are always zero
   function automatic logic [31:0] rd_data(logic [7:0] a,
                                           aflg_top_s s,
                                           logic [4:0] fl);
      logic [31:0] d;
      d = `AFLG_ZERO32;
      unique case (a)
         `AFLG_OFF_OPA: d[7:0] = s.opa;
         `AFLG_OFF_OPB: d[7:0] = s.opb;
         `AFLG_OFF_CMD: begin
            d[`AFLG_CMD_OP] = s.op;
            d[`AFLG_CMD_BIT] = s.bsel;
            d[`AFLG_CMD_SRC] = s.src_f;
            d[`AFLG_CMD_DST] = s.dst_f;
         end
         `AFLG_OFF_RES: d[7:0] = s.res;
         `AFLG_OFF_FLAGS: d[`AFLG_LO] = fl;
         default: d = `AFLG_ZERO32;
      endcase
      return d;
   endfunction : rd_data

   // ----------------------------------------------------------------
   // Bus and execute control
   // ----------------------------------------------------------------
   assign acc = psel && penable;
   assign wr_done = acc && s_r.pready && pwrite;
   assign flags_wr = wr_done && (paddr == `AFLG_OFF_FLAGS);

   // One wait state: pready comes from a flop, so the answer
   // always arrives in the second access cycle
   always_comb begin
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.go = 1'b0;
      if (acc && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = !addr_ok(paddr);
         s_nxt.prdata = pwrite ? `AFLG_ZERO32 :
                        rd_data(paddr, s_r, f.flags);
      end
      if (wr_done) begin
         unique case (paddr)
            `AFLG_OFF_OPA: s_nxt.opa = pwdata[7:0];
            `AFLG_OFF_OPB: s_nxt.opb = pwdata[7:0];
            `AFLG_OFF_CMD: begin
               s_nxt.op = aflg_pkg::aflg_op_e'(pwdata[`AFLG_CMD_OP]);
               s_nxt.bsel = pwdata[`AFLG_CMD_BIT];
               s_nxt.src_f = pwdata[`AFLG_CMD_SRC];
               s_nxt.dst_f = pwdata[`AFLG_CMD_DST];
               s_nxt.go = 1'b1;
            end
            default: s_nxt.go = 1'b0;
         endcase
      end
      // The result register always captures, even when it goes to flags
      if (s_r.go) begin
         s_nxt.res = f.res;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Operand routing to the ALU and flag register
   // ----------------------------------------------------------------
   // The flags register is an ordinary operand when selected
   assign f.op = s_r.op;
   assign f.bsel = s_r.bsel;
   assign f.opa = s_r.opa;
   assign f.opb = s_r.src_f ? {3'b000, f.flags} : s_r.opb;
   assign f.upd_en = s_r.go;
   // An op that owns any flag blocks the data write to all five bits,
   // so a clear aimed at the flags sets zero and keeps the rest
   assign f.fwr_en = (s_r.go && s_r.dst_f && (f.aff == `AFLG_AFF_NONE)) ||
                     flags_wr;
   assign f.fwr_data = s_r.go ? f.res[`AFLG_LO] : pwdata[`AFLG_LO];

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic is_add;
   logic is_sub;
   logic is_rrf;
   logic is_rlf;
   logic [8:0] add_ref;
   assign is_add = s_r.go && (s_r.op == aflg_pkg::AFLG_ADD);
   assign is_sub = s_r.go && (s_r.op == aflg_pkg::AFLG_SUB);
   assign is_rrf = s_r.go && (s_r.op == aflg_pkg::AFLG_RRF);
   assign is_rlf = s_r.go && (s_r.op == aflg_pkg::AFLG_RLF);
   assign add_ref = {1'b0, f.opa} + {1'b0, f.opb};

   property p_dst_flags;
      @(posedge pclk) disable iff (!presetn)
      s_r.go && s_r.dst_f |=>
         ((f.flags & $past(f.aff)) == ($past(f.nflags) & $past(f.aff)));
   endproperty
   a_dst_flags: assert property (p_dst_flags)
      else $error("flag results lost when flags are the destination");

   property p_clr_flags;
      @(posedge pclk) disable iff (!presetn)
      s_r.go && s_r.dst_f && (s_r.op == aflg_pkg::AFLG_CLR) |=>
         f.flags[`AFLG_FLG_Z] &&
         (f.flags[`AFLG_FLG_N] == $past(f.flags[`AFLG_FLG_N])) &&
         (f.flags[`AFLG_FLG_V] == $past(f.flags[`AFLG_FLG_V])) &&
         (f.flags[`AFLG_FLG_DC] == $past(f.flags[`AFLG_FLG_DC])) &&
         (f.flags[`AFLG_FLG_C] == $past(f.flags[`AFLG_FLG_C]));
   endproperty
   a_clr_flags: assert property (p_clr_flags)
      else $error("clear of flags did not give zero set, rest kept");

   property p_upper_zero;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && (paddr == `AFLG_OFF_FLAGS) ##1
      psel && penable ##1 pready |-> (prdata[`AFLG_UP] == 27'h000_0000);
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("flags readback has upper bits set");

   property p_neg;
      @(posedge pclk) disable iff (!presetn)
      s_r.go && f.aff[`AFLG_FLG_N] |=> f.flags[`AFLG_FLG_N] == s_r.res[7];
   endproperty
   a_neg: assert property (p_neg)
      else $error("negative flag differs from result msb");

   property p_ovf;
      @(posedge pclk) disable iff (!presetn)
      is_add |-> f.nflags[`AFLG_FLG_V] ==
         ((f.opa[7] == f.opb[7]) && (f.res[7] != f.opa[7]));
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow flag wrong on add");

   property p_zero;
      @(posedge pclk) disable iff (!presetn)
      s_r.go && f.aff[`AFLG_FLG_Z] && !s_r.dst_f |=>
         f.flags[`AFLG_FLG_Z] == (s_r.res == 8'h00);
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero flag does not match result");

   property p_sub_dc;
      @(posedge pclk) disable iff (!presetn)
      is_sub |-> f.nflags[`AFLG_FLG_DC] == (f.opb[3:0] >= f.opa[3:0]);
   endproperty
   a_sub_dc: assert property (p_sub_dc)
      else $error("nibble borrow polarity wrong on subtract");

   property p_sub_c;
      @(posedge pclk) disable iff (!presetn)
      is_sub |-> f.nflags[`AFLG_FLG_C] == (f.opb >= f.opa);
   endproperty
   a_sub_c: assert property (p_sub_c)
      else $error("borrow polarity wrong on subtract");

   property p_add_c;
      @(posedge pclk) disable iff (!presetn)
      is_add |-> (f.nflags[`AFLG_FLG_C] == add_ref[8]) &&
                 (f.res == add_ref[7:0]);
   endproperty
   a_add_c: assert property (p_add_c)
      else $error("carry out of msb wrong on add");

   property p_rot;
      @(posedge pclk) disable iff (!presetn)
      (is_rrf |-> (f.nflags[`AFLG_FLG_C] == f.opb[0]) &&
                  (f.nflags[`AFLG_FLG_DC] == f.opb[4])) and
      (is_rlf |-> (f.nflags[`AFLG_FLG_C] == f.opb[7]) &&
                  (f.nflags[`AFLG_FLG_DC] == f.opb[3]));
   endproperty
   a_rot: assert property (p_rot)
      else $error("rotate did not load carries from source");

   property p_src_flags;
      @(posedge pclk) disable iff (!presetn)
      s_r.go && s_r.src_f |-> f.opb == {3'b000, f.flags};
   endproperty
   a_src_flags: assert property (p_src_flags)
      else $error("flags not used as source operand");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      s_r.go && (!s_r.dst_f || (f.aff != `AFLG_AFF_NONE)) |=>
         ((f.flags & ~$past(f.aff)) == ($past(f.flags) & ~$past(f.aff)));
   endproperty
   a_hold: assert property (p_hold)
      else $error("unaffected flag changed");

   property p_wait;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable ##1 psel && penable |-> !pready ##1 pready;
   endproperty
   a_wait: assert property (p_wait)
      else $error("access answer not in second access cycle");

   c_clr_flags: cover property (@(posedge pclk) disable iff (!presetn)
      s_r.go && s_r.dst_f && (s_r.op == aflg_pkg::AFLG_CLR));
   c_sub_borrow: cover property (@(posedge pclk) disable iff (!presetn)
      is_sub && !f.nflags[`AFLG_FLG_C]);
   c_rotate: cover property (@(posedge pclk) disable iff (!presetn)
      is_rrf || is_rlf);
   c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
      pready && pslverr);
endmodule : aflg_top

// ==== shared/aflg_cfg.svh ====
`ifndef AFLG_CFG_SVH
`define AFLG_CFG_SVH
// ----------------------------------------------------------------
// Register map, byte addresses on the APB
// ----------------------------------------------------------------
`define AFLG_AW 8
`define AFLG_OFF_OPA 8'h00
`define AFLG_OFF_OPB 8'h04
`define AFLG_OFF_CMD 8'h08
`define AFLG_OFF_RES 8'h0C
`define AFLG_OFF_FLAGS 8'h10
`define AFLG_ZERO32 32'h0000_0000
// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define AFLG_CMD_OP 3:0
`define AFLG_CMD_BIT 6:4
`define AFLG_CMD_SRC 8
`define AFLG_CMD_DST 9
// ----------------------------------------------------------------
// Flag bit positions, width and reset value
// ----------------------------------------------------------------
`define AFLG_FLG_W 5
`define AFLG_FLG_N 4
`define AFLG_FLG_V 3
`define AFLG_FLG_Z 2
`define AFLG_FLG_DC 1
`define AFLG_FLG_C 0
`define AFLG_FLG_POR 5'h00
`define AFLG_LO 4:0
`define AFLG_UP 31:5
// ----------------------------------------------------------------
// Flags touched by each instruction class
// ----------------------------------------------------------------
`define AFLG_AFF_ARITH 5'h1F
`define AFLG_AFF_LOGIC 5'h14
`define AFLG_AFF_CLR 5'h04
`define AFLG_AFF_ROT 5'h17
`define AFLG_AFF_NONE 5'h00
`endif

// ==== shared/aflg_pkg.sv ====
`include "aflg_cfg.svh"
package aflg_pkg;
   typedef enum logic [3:0] {
      AFLG_ADD, AFLG_SUB, AFLG_AND, AFLG_IOR, AFLG_XOR, AFLG_CLR,
      AFLG_RRF, AFLG_RLF, AFLG_MOVW, AFLG_SWAP, AFLG_BSF, AFLG_BCF
   } aflg_op_e;

   // Which flags an instruction writes; others keep their value
   function automatic logic [4:0] aflg_aff_mask(aflg_op_e op);
      unique case (op)
         AFLG_ADD, AFLG_SUB: return `AFLG_AFF_ARITH;
         AFLG_AND, AFLG_IOR, AFLG_XOR: return `AFLG_AFF_LOGIC;
         AFLG_CLR: return `AFLG_AFF_CLR;
         AFLG_RRF, AFLG_RLF: return `AFLG_AFF_ROT;
         default: return `AFLG_AFF_NONE;
      endcase
   endfunction : aflg_aff_mask
endpackage : aflg_pkg

// ==== shared/aflg_if.sv ====
`timescale 1ns/1ps
interface aflg_if;
   aflg_pkg::aflg_op_e op;
   logic [2:0] bsel;
   logic [7:0] opa;
   logic [7:0] opb;
   logic [7:0] res;
   logic [4:0] flags;
   logic [4:0] nflags;
   logic [4:0] aff;
   logic [4:0] fwr_data;
   logic upd_en;
   logic fwr_en;
   modport alu (input op, bsel, opa, opb, flags,
                output res, nflags, aff);
   modport freg (input upd_en, fwr_en, fwr_data, nflags, aff,
                 output flags);
   modport core (output op, bsel, opa, opb, upd_en, fwr_en, fwr_data,
                 input res, nflags, aff, flags);
endinterface : aflg_if

// ==== rtl/aflg_alu.sv ====
`timescale 1ns/1ps
`include "aflg_cfg.svh"
module aflg_alu (
   aflg_if.alu f
);
   // ----------------------------------------------------------------
   // Result and flag derivation, purely combinational
   // ----------------------------------------------------------------
   always_comb begin
      logic [8:0] sum;
      logic [4:0] lo;
      logic [7:0] y;
      logic [7:0] r;
      logic sub;
      sum = '0;
      lo = '0;
      sub = (f.op == aflg_pkg::AFLG_SUB);
      y = sub ? ~f.opa : f.opa;
      r = f.opb;
      f.nflags = f.flags;
      f.aff = aflg_pkg::aflg_aff_mask(f.op);
      unique case (f.op)
         aflg_pkg::AFLG_ADD, aflg_pkg::AFLG_SUB: begin
            // Subtract adds the inverse plus one: carries mean no borrow
            sum = {1'b0, f.opb} + {1'b0, y} + {8'h00, sub};
            lo = {1'b0, f.opb[3:0]} + {1'b0, y[3:0]} + {4'h0, sub};
            r = sum[7:0];
            f.nflags[`AFLG_FLG_C] = sum[8];
            f.nflags[`AFLG_FLG_DC] = lo[4];
            f.nflags[`AFLG_FLG_V] = (f.opb[7] == y[7]) &&
                                    (r[7] != f.opb[7]);
         end
         aflg_pkg::AFLG_AND: r = f.opa & f.opb;
         aflg_pkg::AFLG_IOR: r = f.opa | f.opb;
         aflg_pkg::AFLG_XOR: r = f.opa ^ f.opb;
         aflg_pkg::AFLG_CLR: r = 8'h00;
         aflg_pkg::AFLG_RRF: begin
            r = {f.flags[`AFLG_FLG_C], f.opb[7:1]};
            f.nflags[`AFLG_FLG_C] = f.opb[0];
            f.nflags[`AFLG_FLG_DC] = f.opb[4];
         end
         aflg_pkg::AFLG_RLF: begin
            r = {f.opb[6:0], f.flags[`AFLG_FLG_C]};
            f.nflags[`AFLG_FLG_C] = f.opb[7];
            f.nflags[`AFLG_FLG_DC] = f.opb[3];
         end
         aflg_pkg::AFLG_MOVW: r = f.opa;
         aflg_pkg::AFLG_SWAP: r = {f.opb[3:0], f.opb[7:4]};
         aflg_pkg::AFLG_BSF: r = f.opb | (8'h01 << f.bsel);
         aflg_pkg::AFLG_BCF: r = f.opb & ~(8'h01 << f.bsel);
         default: r = f.opb;
      endcase
      f.nflags[`AFLG_FLG_N] = r[7];
      f.nflags[`AFLG_FLG_Z] = (r == 8'h00);
      f.res = r;
   end
endmodule : aflg_alu

// ==== rtl/aflg_freg.sv ====
`timescale 1ns/1ps
`include "aflg_cfg.svh"
module aflg_freg (
   input wire logic pclk,
   input wire logic presetn,
   aflg_if.freg f
);
   typedef struct packed {
      logic [4:0] flags;
   } aflg_freg_s;
   aflg_freg_s s_r;
   aflg_freg_s s_nxt;

   // ----------------------------------------------------------------
   // Per-bit update: ALU result beats a plain write to the register
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      for (int i = 0; i < `AFLG_FLG_W; i++) begin
         if (f.upd_en && f.aff[i]) begin
            s_nxt.flags[i] = f.nflags[i];
         end else if (f.fwr_en) begin
            s_nxt.flags[i] = f.fwr_data[i];
         end
      end
   end

   // Untouched bits hold, so unaffected flags keep their value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.flags <= `AFLG_FLG_POR;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign f.flags = s_r.flags;
endmodule : aflg_freg

// ==== testbench/tb_alu_arith_flag_logic.sv ====
`timescale 1ns/1ps
`include "aflg_cfg.svh"
module tb_alu_arith_flag_logic;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int fail_count;
   int comparisons;
   logic [4:0] fl_m;
   logic [7:0] res_m;

   aflg_top uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );

   // ------------------------------------------------------------
   // Clock, free running with a 20 ns period
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ------------------------------------------------------------
   // Bus tasks and comparison
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Ready and read data are sampled at the rising edge, before the
   // design's own updates land; one idle cycle follows each transfer.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         $display("[ERR] %0t no ready", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic experr, input string what);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      chk(rd, exp, what);
      chk({31'h0000_0000, err}, {31'h0000_0000, experr}, "slave error");
   endtask : rd_chk

   // ------------------------------------------------------------
   // Reference flag model and one instruction step
   // ------------------------------------------------------------
   // Flags outside an op's set keep their value, also when the flags
   // register is the destination; only ops touching no flag write it.
   task automatic step(input logic [3:0] op, input logic [7:0] a, b,
                       input logic [2:0] bn, input logic src, dst);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] o;
      logic [4:0] af;
      logic [4:0] al;
      logic [4:0] keep;
      logic v;
      o = src ? {3'b000, fl_m} : b;
      s = 9'h000;
      h = 5'h00;
      v = 1'b0;
      af = 5'h00;
      case (op)
         4'h0: begin
            s = {1'b0, o} + {1'b0, a};
            h = {1'b0, o[3:0]} + {1'b0, a[3:0]};
            v = (a[7] == o[7]) && (s[7] != o[7]);
            af = 5'h1F;
         end
         4'h1: begin // Add of the complement, carries are inverted borrows
            s = {1'b0, o} + {1'b0, ~a} + 9'h001;
            h = {1'b0, o[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
            v = (a[7] != o[7]) && (s[7] != o[7]);
            af = 5'h1F;
         end
         4'h2: begin s[7:0] = o & a; af = 5'h14; end
         4'h3: begin s[7:0] = o | a; af = 5'h14; end
         4'h4: begin s[7:0] = o ^ a; af = 5'h14; end
         4'h5: begin s[7:0] = 8'h00; af = 5'h04; end
         4'h6: begin s = {o[0], fl_m[0], o[7:1]}; h[4] = o[4]; af = 5'h17; end
         4'h7: begin s = {o[7], o[6:0], fl_m[0]}; h[4] = o[3]; af = 5'h17; end
         4'h8: s[7:0] = a;
         4'h9: s[7:0] = {o[3:0], o[7:4]};
         4'hA: s[7:0] = o | (8'h01 << bn);
         4'hB: s[7:0] = o & ~(8'h01 << bn);
         default: s[7:0] = o;
      endcase
      res_m = s[7:0];
      al = {res_m[7], v, res_m == 8'h00, h[4], s[8]};
      keep = (dst && af == 5'h00) ? res_m[4:0] : fl_m;
      fl_m = (af & al) | (~af & keep);
      wr_reg(`AFLG_OFF_OPA, {24'h00_0000, a});
      wr_reg(`AFLG_OFF_OPB, {24'h00_0000, b});
      wr_reg(`AFLG_OFF_CMD, {16'h0000, 6'h00, dst, src, 1'b0, bn, op});
      rd_chk(`AFLG_OFF_RES, {24'h00_0000, res_m}, 1'b0, "result");
      rd_chk(`AFLG_OFF_FLAGS, {27'h000_0000, fl_m}, 1'b0, "flags");
   endtask : step

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   // Whole run takes well under a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      fail_count = 0;
      comparisons = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      fl_m = 5'h00;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(`AFLG_OFF_FLAGS, 32'h0000_0000, 1'b0, "flags reset");
      wr_reg(`AFLG_OFF_FLAGS, 32'hFFFF_FFFF);
      rd_chk(`AFLG_OFF_FLAGS, 32'h0000_001F, 1'b0, "flags width");
      fl_m = 5'h1F;
      $display("test register done");
      step(4'h0, 8'h01, 8'hFF, 3'h0, 1'b0, 1'b0);
      step(4'h0, 8'h50, 8'h50, 3'h0, 1'b0, 1'b0);
      step(4'h0, 8'h08, 8'h08, 3'h0, 1'b0, 1'b0);
      step(4'h1, 8'h01, 8'h01, 3'h0, 1'b0, 1'b0);
      step(4'h1, 8'h02, 8'h01, 3'h0, 1'b0, 1'b0);
      step(4'h1, 8'h01, 8'h80, 3'h0, 1'b0, 1'b0);
      step(4'h2, 8'hF0, 8'h0F, 3'h0, 1'b0, 1'b0);
      step(4'h3, 8'h80, 8'h01, 3'h0, 1'b0, 1'b0);
      step(4'h4, 8'hFF, 8'hFF, 3'h0, 1'b0, 1'b0);
      step(4'h5, 8'h00, 8'h5A, 3'h0, 1'b0, 1'b0);
      step(4'h6, 8'h00, 8'h11, 3'h0, 1'b0, 1'b0);
      step(4'h7, 8'h00, 8'h88, 3'h0, 1'b0, 1'b0);
      step(4'h6, 8'h00, 8'hEE, 3'h0, 1'b0, 1'b0);
      step(4'h7, 8'h00, 8'h77, 3'h0, 1'b0, 1'b0);
      step(4'h8, 8'h00, 8'h33, 3'h0, 1'b0, 1'b0);
      step(4'h9, 8'h00, 8'h3C, 3'h0, 1'b0, 1'b0);
      step(4'hA, 8'h00, 8'h00, 3'h7, 1'b0, 1'b0);
      step(4'hB, 8'h00, 8'hFF, 3'h0, 1'b0, 1'b0);
      step(4'hC, 8'h00, 8'h42, 3'h0, 1'b0, 1'b0);
      step(4'hF, 8'h00, 8'h24, 3'h0, 1'b0, 1'b0);
      $display("test flags done");
      wr_reg(`AFLG_OFF_FLAGS, 32'h0000_001B);
      fl_m = 5'h1B;
      step(4'h5, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1);
      step(4'h0, 8'h10, 8'h00, 3'h0, 1'b1, 1'b1);
      step(4'h8, 8'h15, 8'h00, 3'h0, 1'b0, 1'b1);
      step(4'hA, 8'h00, 8'h00, 3'h3, 1'b1, 1'b1);
      step(4'hB, 8'h00, 8'h00, 3'h2, 1'b1, 1'b1);
      step(4'h9, 8'h00, 8'h00, 3'h0, 1'b1, 1'b0);
      $display("test destination done");
      wr_reg(`AFLG_OFF_RES, 32'h0000_00AA);
      rd_chk(`AFLG_OFF_RES, {24'h00_0000, res_m}, 1'b0, "res kept");
      wr_reg(8'h14, 32'h0000_00FF);
      rd_chk(8'h14, 32'h0000_0000, 1'b1, "unmapped read");
      rd_chk(`AFLG_OFF_FLAGS, {27'h000_0000, fl_m}, 1'b0, "kept");
      $display("test map done");
      give_verdict();
   end
endmodule : tb_alu_arith_flag_logic
